// ---- rtl/crr_defs.vh ----
// Constants for the capacitance result and reference-count register bank.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CRR_DEFS_VH
`define CRR_DEFS_VH

// Register word addresses
`define CRR_ADDR_CH2_UPPER     8'h04
`define CRR_ADDR_CH2_LOWER     8'h05
`define CRR_ADDR_CH3_UPPER     8'h06
`define CRR_ADDR_CH3_LOWER     8'h07
`define CRR_ADDR_CH0_INTERVAL  8'h08
`define CRR_ADDR_CH1_INTERVAL  8'h09
`define CRR_ADDR_CH2_INTERVAL  8'h0A

// Field layout of the upper and lower result words
`define CRR_BIT_WATCHDOG       13
`define CRR_BIT_AMPLITUDE      12
`define CRR_UPPER_MSB          11
`define CRR_LOWER_MSB          15
`define CRR_RESULT_MSB         27
`define CRR_SPLIT_LSB          16

// Widths and reset values
`define CRR_WORD_W             16
`define CRR_RESULT_W           28
`define CRR_ADDR_W             8
`define CRR_INTERVAL_RESET     16'h0080
`define CRR_WORD_ZERO          16'h0000
`define CRR_RESULT_ZERO        28'h0000000

// Conversion length is interval times 16 reference periods
`define CRR_TICKS_SHIFT        4
`define CRR_TICK_W             20
`define CRR_TICK_ZERO          20'h00000
`define CRR_TICK_ONE           20'h00001

`endif

// ---- rtl/crr_conv_timer.v ----
// Conversion interval timer for one channel.
// Assumes the reference clock level is synchronous to clock and far slower.
`include "crr_defs.vh"

module crr_conv_timer (
  // Clock and reset
  input  wire                    clock,
  input  wire                    rst_n,
  // Channel reference clock level and programmed interval
  input  wire                    ref_level,
  input  wire [`CRR_WORD_W-1:0]  interval,
  // One-cycle pulse at the end of each conversion
  output reg                     done_q
);

  reg                    ref_prev_q;
  reg [`CRR_TICK_W-1:0]  ticks_q;
  wire                   ref_rise;
  wire [`CRR_TICK_W-1:0] target;

  ////////////////////////////////////////////////////////////////////////////
  // Rising edges of the reference clock are the unit of time
  assign ref_rise = ref_level & ~ref_prev_q;
  // Interval times sixteen, as reference periods
  assign target   = {interval, {`CRR_TICKS_SHIFT{1'b0}}};

  // Count reference periods; a changed interval takes effect at once
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev_q <= 1'b0;
      ticks_q    <= `CRR_TICK_ZERO;
      done_q     <= 1'b0;
    end else begin
      ref_prev_q <= ref_level;
      done_q     <= 1'b0;
      if (ref_rise) begin
        if (ticks_q + `CRR_TICK_ONE >= target) begin
          ticks_q <= `CRR_TICK_ZERO;
          done_q  <= 1'b1;
        end else begin
          ticks_q <= ticks_q + `CRR_TICK_ONE;
        end
      end
    end
  end

endmodule

// ---- rtl/crr_regs.v ----
// Result words for channels 2 and 3 and reference counts for channels 0-2.
// Assumes a serial bus engine drives the word access port in clock domain.
// Assumes the engine never strobes read and write in the same cycle.
// Assumes results and events arrive from the conversion core, clock domain.
`include "crr_defs.vh"

module crr_regs #(
  parameter WIDE_RESULT = 1                        // 1: 28-bit, 0: 12-bit variant
) (
  // Clock and reset
  input  wire                    clock,
  input  wire                    reset_n,
  // Register word access from the serial bus engine
  input  wire [`CRR_ADDR_W-1:0]  reg_addr,
  input  wire                    reg_wr,
  input  wire [`CRR_WORD_W-1:0]  reg_wdata,
  input  wire                    reg_rd,
  output reg  [`CRR_WORD_W-1:0]  reg_rdata_q,
  // Per-channel reference clocks, channels 0 to 2
  input  wire [2:0]              channel_reference_clock,
  output wire [2:0]              conv_done,
  // Conversion core results and events
  input  wire                    ch2_result_valid,
  input  wire [`CRR_RESULT_W-1:0] ch2_result_in,
  input  wire                    ch2_watchdog_event,
  input  wire                    ch2_amplitude_unsettled,
  input  wire                    ch3_result_valid,
  input  wire [`CRR_RESULT_W-1:0] ch3_result_in,
  input  wire                    ch3_watchdog_event,
  input  wire                    ch3_amplitude_unsettled,
  input  wire                    amplitude_warning_enable
);

  reg                     rst_meta_q;
  reg                     rst_sync_q;
  reg [`CRR_WORD_W-1:0]   ch0_interval_count;
  reg [`CRR_WORD_W-1:0]   ch1_interval_count;
  reg [`CRR_WORD_W-1:0]   ch2_interval_count;
  reg [`CRR_RESULT_W-1:0] ch2_result;
  reg [`CRR_RESULT_W-1:0] ch3_result;
  reg [`CRR_WORD_W-1:0]   ch2_lower_shadow_q;
  reg [`CRR_WORD_W-1:0]   ch3_lower_shadow_q;
  reg                     ch2_watchdog_timeout_flag;
  reg                     ch2_amplitude_warning_flag;
  reg                     ch3_watchdog_timeout_flag;
  reg                     ch3_amplitude_warning_flag;
  reg [`CRR_WORD_W-1:0]   rdata_d;
  wire                    rd_ch2_upper;
  wire                    rd_ch3_upper;
  wire [`CRR_WORD_W*3-1:0] intervals;

  ////////////////////////////////////////////////////////////////////////////
  // Upper word image: flags at 13:12, then result bits 27:16, or bits 11:0 in the 12-bit variant
  // Bits 15:14 are reserved and always read zero
  function [`CRR_WORD_W-1:0] upper_word;
    input                     wd;
    input                     aw;
    input [`CRR_RESULT_W-1:0] res;
    begin
      upper_word = `CRR_WORD_ZERO;
      upper_word[`CRR_BIT_WATCHDOG]  = wd;
      upper_word[`CRR_BIT_AMPLITUDE] = aw;
      if (WIDE_RESULT != 0)
        upper_word[`CRR_UPPER_MSB:0] = res[`CRR_RESULT_MSB:`CRR_SPLIT_LSB];
      else
        upper_word[`CRR_UPPER_MSB:0] = res[`CRR_UPPER_MSB:0];
    end
  endfunction

  // Read strobe aimed at one word address
  function rd_hit;
    input                   rd;
    input [`CRR_ADDR_W-1:0] addr;
    input [`CRR_ADDR_W-1:0] target;
    begin
      rd_hit = rd && (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval count registers; reserved low values are not filtered
  // Storing them as-is keeps writes simple; such counts just run short
  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ch0_interval_count <= `CRR_INTERVAL_RESET;
      ch1_interval_count <= `CRR_INTERVAL_RESET;
      ch2_interval_count <= `CRR_INTERVAL_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `CRR_ADDR_CH0_INTERVAL: ch0_interval_count <= reg_wdata;
        `CRR_ADDR_CH1_INTERVAL: ch1_interval_count <= reg_wdata;
        `CRR_ADDR_CH2_INTERVAL: ch2_interval_count <= reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One timer per channel, each on its own reference clock
  // Counts restart at reset and at each conversion end; a new interval applies mid-count
  assign intervals = {ch2_interval_count, ch1_interval_count, ch0_interval_count};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_timer
      crr_conv_timer u_timer (
        .clock     (clock),
        .rst_n     (rst_sync_q),
        .ref_level (channel_reference_clock[gi]),
        .interval  (intervals[gi*`CRR_WORD_W +: `CRR_WORD_W]),
        .done_q    (conv_done[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Result capture from the conversion core
  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ch2_result <= `CRR_RESULT_ZERO;
      ch3_result <= `CRR_RESULT_ZERO;
    end else begin
      if (ch2_result_valid)
        ch2_result <= ch2_result_in;
      if (ch3_result_valid)
        ch3_result <= ch3_result_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read strobes that clear flags and freeze lower halves
  assign rd_ch2_upper = rd_hit(reg_rd, reg_addr, `CRR_ADDR_CH2_UPPER);
  assign rd_ch3_upper = rd_hit(reg_rd, reg_addr, `CRR_ADDR_CH3_UPPER);

  // Sticky flags; a new event in the read cycle survives the clear
  // Set wins so an event is never lost to a read
  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ch2_watchdog_timeout_flag  <= 1'b0;
      ch2_amplitude_warning_flag <= 1'b0;
      ch3_watchdog_timeout_flag  <= 1'b0;
      ch3_amplitude_warning_flag <= 1'b0;
    end else begin
      ch2_watchdog_timeout_flag  <= ch2_watchdog_event |
                                    (ch2_watchdog_timeout_flag & ~rd_ch2_upper);
      ch2_amplitude_warning_flag <= (ch2_amplitude_unsettled & amplitude_warning_enable) |
                                    (ch2_amplitude_warning_flag & ~rd_ch2_upper);
      ch3_watchdog_timeout_flag  <= ch3_watchdog_event |
                                    (ch3_watchdog_timeout_flag & ~rd_ch3_upper);
      ch3_amplitude_warning_flag <= (ch3_amplitude_unsettled & amplitude_warning_enable) |
                                    (ch3_amplitude_warning_flag & ~rd_ch3_upper);
    end
  end

  // Lower half held at the upper read so the pair is one conversion
  // Trade-off: the lower word stays stale until the upper word is read
  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ch2_lower_shadow_q <= `CRR_WORD_ZERO;
      ch3_lower_shadow_q <= `CRR_WORD_ZERO;
    end else begin
      if (rd_ch2_upper)
        ch2_lower_shadow_q <= ch2_result[`CRR_LOWER_MSB:0];
      if (rd_ch3_upper)
        ch3_lower_shadow_q <= ch3_result[`CRR_LOWER_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped words and 12-bit lower words read zero
  always @* begin
    rdata_d = `CRR_WORD_ZERO;
    case (reg_addr)
      `CRR_ADDR_CH2_UPPER:
        rdata_d = upper_word(ch2_watchdog_timeout_flag,
                             ch2_amplitude_warning_flag, ch2_result);
      `CRR_ADDR_CH2_LOWER:
        if (WIDE_RESULT != 0)
          rdata_d = ch2_lower_shadow_q;
      `CRR_ADDR_CH3_UPPER:
        rdata_d = upper_word(ch3_watchdog_timeout_flag,
                             ch3_amplitude_warning_flag, ch3_result);
      `CRR_ADDR_CH3_LOWER:
        if (WIDE_RESULT != 0)
          rdata_d = ch3_lower_shadow_q;
      `CRR_ADDR_CH0_INTERVAL: rdata_d = ch0_interval_count;
      `CRR_ADDR_CH1_INTERVAL: rdata_d = ch1_interval_count;
      `CRR_ADDR_CH2_INTERVAL: rdata_d = ch2_interval_count;
      default: rdata_d = `CRR_WORD_ZERO;
    endcase
  end

  // Read data registered one cycle after the strobe
  // Held between reads so address changes never disturb the output
  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q)
      reg_rdata_q <= `CRR_WORD_ZERO;
    else if (reg_rd)
      reg_rdata_q <= rdata_d;
  end

endmodule

// ---- tb/crr_host_model.sv ----
// Host-side model issuing register word reads and writes.
// Assumes the bench calls its tasks; lines change at falling edges.
module crr_host_model (
  // Clock
  input  logic        clock,
  // Register word port
  output logic [7:0]  reg_addr,
  output logic        reg_wr,
  output logic [15:0] reg_wdata,
  output logic        reg_rd,
  input  logic [15:0] reg_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    if (a inside {8'h08, 8'h09, 8'h0A} && v < 16'h0100) v = 16'h0100;
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  // Read data is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    v = reg_rdata_q;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

// ---- tb/crr_regs_chk.sv ----
// Port checker for the result and interval register bank.
// Assumes it is bound onto crr_regs and sees only its ports.
module crr_regs_chk (
  // Clock and reset
  input logic        clock,
  input logic        reset_n,
  // Register port
  input logic [7:0]  reg_addr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata_q,
  // Timers and events
  input logic [2:0]  conv_done,
  input logic        ch2_watchdog_event,
  input logic        ch2_amplitude_unsettled,
  input logic        ch3_watchdog_event,
  input logic        ch3_amplitude_unsettled,
  input logic        amplitude_warning_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Edges since release; events during synchroniser wake-up are lost
  logic [1:0] up_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      up_q <= 2'h0;
    else if (!up_q[1])
      up_q <= up_q + 2'h1;
  end
  wire rd2 = reg_rd && reg_addr == 8'h04;
  wire rd3 = reg_rd && reg_addr == 8'h06;
  wire aw2 = ch2_amplitude_unsettled && amplitude_warning_enable;
  wire aw3 = ch3_amplitude_unsettled && amplitude_warning_enable;
  ////////////////////////////////////////////////////////////
  // Two upper reads with no fresh event between them
  sequence s_wd2_quiet;
    rd2 && !ch2_watchdog_event ##1 !ch2_watchdog_event ##1 rd2;
  endsequence
  sequence s_aw2_quiet;
    rd2 && !aw2 ##1 !aw2 ##1 rd2;
  endsequence
  sequence s_wd3_quiet;
    rd3 && !ch3_watchdog_event ##1 !ch3_watchdog_event ##1 rd3;
  endsequence
  sequence s_aw3_quiet;
    rd3 && !aw3 ##1 !aw3 ##1 rd3;
  endsequence
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  a_wd2_sets: assert property (up_q[1] && ch2_watchdog_event ##1 rd2 |=> reg_rdata_q[13])
    else $error("ch2 watchdog flag missing");
  a_wd2_clears: assert property (s_wd2_quiet |=> !reg_rdata_q[13])
    else $error("ch2 watchdog flag not cleared");
  a_wd2_set_wins: assert property (up_q[1] && rd2 && ch2_watchdog_event ##2 rd2
    |=> reg_rdata_q[13])
    else $error("ch2 watchdog event lost to read");
  a_aw2_sets: assert property (up_q[1] && aw2 ##1 rd2 |=> reg_rdata_q[12])
    else $error("ch2 amplitude flag missing");
  a_aw2_clears: assert property (s_aw2_quiet |=> !reg_rdata_q[12])
    else $error("ch2 amplitude flag not cleared");
  a_wd3_sets: assert property (up_q[1] && ch3_watchdog_event ##1 rd3 |=> reg_rdata_q[13])
    else $error("ch3 watchdog flag missing");
  a_wd3_clears: assert property (s_wd3_quiet |=> !reg_rdata_q[13])
    else $error("ch3 watchdog flag not cleared");
  a_aw3_sets: assert property (up_q[1] && aw3 ##1 rd3 |=> reg_rdata_q[12])
    else $error("ch3 amplitude flag missing");
  a_aw3_clears: assert property (s_aw3_quiet |=> !reg_rdata_q[12])
    else $error("ch3 amplitude flag not cleared");
  a_top_bits_zero: assert property (rd2 || rd3 |=> reg_rdata_q[15:14] == 2'b00)
    else $error("upper word top bits not zero");
  a_done_single: assert property (conv_done[2] |=> !conv_done[2])
    else $error("ch2 done longer than one cycle");
endmodule
bind crr_regs crr_regs_chk u_chk (
  .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .conv_done(conv_done),
  .ch2_watchdog_event(ch2_watchdog_event),
  .ch2_amplitude_unsettled(ch2_amplitude_unsettled),
  .ch3_watchdog_event(ch3_watchdog_event),
  .ch3_amplitude_unsettled(ch3_amplitude_unsettled),
  .amplitude_warning_enable(amplitude_warning_enable));

// ---- tb/crr_regs_tb_top.sv ----
// Self-checking bench for the result and interval register bank.
// Assumes the host model and the bound checker sit beside the design.
module crr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata_q, d, rdn;
  logic        reg_wr, reg_rd, en = 1'b0;
  logic [2:0]  ref_clk = 3'h0, conv_done, ev2 = 3'h0, ev3 = 3'h0;
  logic [27:0] res2 = 28'h0000000, res3 = 28'h0000000;
  int          bad_count = 0, checked = 0, at [3];
  always #4 clock = ~clock;
  crr_regs #(.WIDE_RESULT(1)) dut (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .channel_reference_clock(ref_clk), .conv_done(conv_done),
    .ch2_result_valid(ev2[2]), .ch2_result_in(res2), .ch2_watchdog_event(ev2[1]),
    .ch2_amplitude_unsettled(ev2[0]), .ch3_result_valid(ev3[2]),
    .ch3_result_in(res3), .ch3_watchdog_event(ev3[1]),
    .ch3_amplitude_unsettled(ev3[0]), .amplitude_warning_enable(en));
  crr_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  // 12-bit variant beside the 28-bit one, sharing every input
  crr_regs #(.WIDE_RESULT(0)) dut_narrow (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(rdn),
    .channel_reference_clock(ref_clk), .conv_done(),
    .ch2_result_valid(ev2[2]), .ch2_result_in(res2), .ch2_watchdog_event(ev2[1]),
    .ch2_amplitude_unsettled(ev2[0]), .ch3_result_valid(ev3[2]),
    .ch3_result_in(res3), .ch3_watchdog_event(ev3[1]),
    .ch3_amplitude_unsettled(ev3[0]), .amplitude_warning_enable(en));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Events stand one cycle; cleared while the next read is issued
  task automatic fire(input logic [2:0] e2, input logic [2:0] e3, input logic e);
    @(negedge clock);
    {ev2, ev3, en} = {e2, e3, e};
    fork
      begin
        @(negedge clock);
        {ev2, ev3, en} = 7'h00;
      end
    join_none
  endtask
  ////////////////////////////////////////////////////////////
  task automatic test_regs;
    host.rd(8'h08, d); check("ch0 interval", d, 16'h0080);
    host.rd(8'h09, d); check("ch1 interval", d, 16'h0080);
    host.wr(8'h0A, 16'h0100);
    host.rd(8'h0A, d); check("ch2 interval", d, 16'h0100);
    host.rd(8'h1F, d); check("unmapped", d, 16'h0000);
    host.wr(8'h04, 16'hFFFF);
    host.rd(8'h04, d); check("ch2 upper ro", d, 16'h0000);
    $display("test_regs done");
  endtask
  task automatic test_results;
    res2 = 28'hABC1234;
    res3 = 28'h5DEF987;
    fire(3'h7, 3'h7, 1'b1);
    host.rd(8'h04, d); check("ch2 upper", d, 16'h3ABC);
    check("ch2 upper narrow", rdn, 16'h3234);
    host.rd(8'h04, d); check("ch2 cleared", d, 16'h0ABC);
    host.rd(8'h05, d); check("ch2 lower", d, 16'h1234);
    check("ch2 lower narrow", rdn, 16'h0000);
    res2 = 28'hFFFFFFF;
    fire(3'h4, 3'h0, 1'b0);
    host.rd(8'h05, d); check("ch2 lower held", d, 16'h1234);
    host.rd(8'h06, d); check("ch3 upper", d, 16'h35DE);
    check("ch3 upper narrow", rdn, 16'h3987);
    host.rd(8'h07, d); check("ch3 lower", d, 16'hF987);
    fire(3'h0, 3'h1, 1'b0);
    host.rd(8'h06, d); check("ch3 aw masked", d, 16'h05DE);
    fire(3'h0, 3'h3, 1'b1);
    host.rd(8'h06, d); check("ch3 flags next read", d, 16'h35DE);
    host.rd(8'h06, d); check("ch3 cleared", d, 16'h05DE);
    // Event in the read cycle: old value read, flag kept
    fork
      fire(3'h2, 3'h0, 1'b0);
      host.rd(8'h04, d);
    join
    check("ch2 set wins old", d, 16'h0FFF);
    host.rd(8'h04, d); check("ch2 set wins", d, 16'h2FFF);
    host.rd(8'h05, d); check("ch2 lower new", d, 16'hFFFF);
    $display("test_results done");
  endtask
  // Mid-run reset returns the ch2 interval and both upper words to their reset values
  task automatic test_reset;
    @(negedge clock);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    check("done after reset", {13'h0000, conv_done}, 16'h0000);
    repeat (2) @(negedge clock);
    host.rd(8'h0A, d); check("ch2 interval reset", d, 16'h0080);
    host.rd(8'h04, d); check("ch2 upper reset", d, 16'h0000);
    host.rd(8'h06, d); check("ch3 upper reset", d, 16'h0000);
    $display("test_reset done");
  endtask
  // Reference edges counted until each channel ends its conversion
  task automatic test_timer;
    at = '{0, 0, 0};
    for (int n = 1; n <= 4096; n++) begin
      for (int k = 0; k < 4; k++) begin
        @(negedge clock);
        ref_clk = (k < 2) ? 3'h7 : 3'h0;
        for (int c = 0; c < 3; c++)
          if (conv_done[c] === 1'b1 && at[c] == 0) at[c] = n;
      end
    end
    check("ch0 done edge", 16'(at[0]), 16'd2048);
    check("ch1 done edge", 16'(at[1]), 16'd2048);
    check("ch2 done edge", 16'(at[2]), 16'd4096);
    $display("test_timer done");
  endtask
  initial begin
    #300us;
    bad_count++;
    results;
  end
  initial begin
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    test_regs;
    test_results;
    test_timer;
    test_reset;
    results;
  end
endmodule
